// File: hdl/ebh_pkg.sv
package ebh_pkg;

  // ---------------------------------------------------------------------------
  // bus widths
  // ---------------------------------------------------------------------------
  localparam int unsigned DATA_W = 32;  // peripheral data bus width
  localparam int unsigned ADDR_W = 32;  // peripheral address bus width
  localparam int unsigned BE_W   = 4;   // byte-enable lines

  // ---------------------------------------------------------------------------
  // timing and reset values
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_DIV_HALF = 1;             // sys cycles per half period of bus clock
  localparam logic [3:0]  RST_STRETCH  = 4'h8;          // sys cycles bus reset is held after release
  localparam logic [7:0]  ERR_CNT_RST  = 8'h00;         // error counter value after reset
  localparam logic        PRI_HIGH     = 1'b0;          // priority level meaning high

  // ---------------------------------------------------------------------------
  // device ownership states
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    EBH_OWN     = 2'b00,  // device drives the bus
    EBH_GRANTED = 2'b01,  // external master owns the bus
    EBH_RECLAIM = 2'b10,  // reclaim asked, waiting for hold release
    EBH_TURN    = 2'b11   // one idle cycle before device drives again
  } ebh_own_t;

  // transfer source for device-driven cycles
  typedef enum logic {
    EBH_SRC_PERIPH = 1'b0,  // peripheral controller
    EBH_SRC_DMA    = 1'b1   // dma controller
  } ebh_src_t;

endpackage

// File: hdl/ebh_if.sv
`timescale 1ns/10ps
// shared peripheral bus between device and external master; each line has
// one output and one active-low output enable per party
interface ebh_if;
  // clock and reset from device
  logic        bus_clk;
  logic        bus_rst;
  // ownership handshake
  logic        hold_req;
  logic        hold_grant;
  logic        reclaim_req;
  logic        xfer_priority;
  logic        xfer_req;
  logic        xfer_ack;
  logic        ready;
  logic        error;
  // device side of the shared lines
  logic [31:0] dev_data_o;
  logic        dev_data_oe_n;
  logic [31:0] dev_addr_o;
  logic [3:0]  dev_be_o;
  logic        dev_rw_o;
  logic        dev_last_o;
  logic        dev_we_o;
  logic        dev_ctl_oe_n;
  // master side of the shared lines
  logic [31:0] mst_data_o;
  logic        mst_data_oe_n;
  logic [31:0] mst_addr_o;
  logic [3:0]  mst_be_o;
  logic        mst_rw_o;
  logic        mst_last_o;
  logic        mst_we_o;
  logic        mst_ctl_oe_n;
  // resolved wire levels (driven by the bench)
  logic [31:0] data;
  logic [31:0] addr;
  logic [3:0]  be;
  logic        rw;
  logic        last;
  logic        we;

  modport dev (
    output bus_clk, bus_rst, hold_grant, reclaim_req, xfer_ack,
    input  hold_req, xfer_priority, xfer_req, ready, error,
    output dev_data_o, dev_data_oe_n, dev_addr_o, dev_be_o, dev_rw_o, dev_last_o, dev_we_o, dev_ctl_oe_n,
    input  data, addr, be, rw, last, we
  );
  modport mst (
    input  bus_clk, bus_rst, hold_grant, reclaim_req, xfer_ack, ready,
    output hold_req, xfer_priority, xfer_req, error,
    output mst_data_o, mst_data_oe_n, mst_addr_o, mst_be_o, mst_rw_o, mst_last_o, mst_we_o, mst_ctl_oe_n,
    input  data
  );
endinterface

// File: hdl/ebh_dev.sv
`timescale 1ns/10ps
// Operation
// - master raises hold request to own bus
// - device grants hold to requesting master
// - master gives priority, low means high
// - device raises reclaim request to regain bus
// - device drives shared lines only when owner
// - byte enables are inputs while master owns
// - byte enables whole-cycle or per-byte write mode
// - byte enables from peripheral or dma controller
// - write strobe is and of byte enables
// - read/write from peripheral or dma controller
// - master raises transfer request when ready
// - device acknowledges each master data transfer
// - device records peripheral error reports
// - device outputs peripheral bus clock
// - device outputs peripheral bus reset
// - data phase waits for peripheral ready
module ebh_dev (
  // clock and reset
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_rst_n,
  // device transfer request from internal controllers
  input  wire logic                    i_xfer_start,
  input  wire ebh_pkg::ebh_src_t       i_xfer_src,
  input  wire logic                    i_xfer_write,
  input  wire logic                    i_xfer_last,
  input  wire logic [31:0]             i_xfer_addr,
  input  wire logic [31:0]             i_xfer_wdata,
  input  wire logic [3:0]              i_periph_be,
  input  wire logic [3:0]              i_dma_be,
  input  wire logic                    i_periph_rw,
  input  wire logic                    i_dma_rw,
  input  wire logic                    i_be_per_byte,
  input  wire logic                    i_need_bus,
  output logic                         o_xfer_busy,
  output logic                         o_xfer_done,
  output logic [31:0]                  o_xfer_rdata,
  // status toward the system
  output logic                         o_master_owns,
  output logic                         o_mst_high_pri,
  output logic [7:0]                   o_err_count,
  output logic                         o_err_seen,
  // external bus
  ebh_if.dev                           bus
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    ebh_pkg::ebh_own_t own;        // ownership state
    logic              hreq_m;     // hold request sync stage 1
    logic              hreq_s;     // hold request synced
    logic              xreq_m;     // transfer request sync stage 1
    logic              xreq_s;     // transfer request synced
    logic              xreq_d;     // previous synced transfer request
    logic              rdy_m;      // ready sync stage 1
    logic              rdy_s;      // ready synced
    logic              err_m;      // error sync stage 1
    logic              err_s;      // error synced
    logic              err_d;      // previous synced error
    logic              pri_m;      // priority sync stage 1
    logic              pri_s;      // priority synced
    logic              ack;        // master transfer ack pulse
    logic              busy;       // device data phase active
    logic              done;       // device transfer done pulse
    logic              per_byte;   // latched byte-enable mode
    ebh_pkg::ebh_src_t src;        // latched transfer source
    logic              wr;         // latched direction
    logic              last;       // latched burst-last
    logic [31:0]       addr;       // latched address
    logic [31:0]       wdata;      // latched write data
    logic [31:0]       rdata;      // captured read data
    logic [7:0]        errs;       // error count
    logic              err_seen;   // sticky error flag
    logic              clk_out;    // bus clock level
    logic [3:0]        rst_cnt;    // bus reset stretch
  } ebh_dev_st_t;

  ebh_dev_st_t st_r;   // registered state
  ebh_dev_st_t st_nxt; // next state
  logic [3:0]  be_sel; // selected controller byte enables
  logic        rw_sel; // selected controller direction

  // ---------------------------------------------------------------------------
  // controller selection
  // ---------------------------------------------------------------------------
  always_comb begin
    // pick byte enables and direction by transfer source
    be_sel = (st_r.src == ebh_pkg::EBH_SRC_DMA) ? i_dma_be : i_periph_be;
    rw_sel = (st_r.src == ebh_pkg::EBH_SRC_DMA) ? i_dma_rw : i_periph_rw;
    // whole-cycle mode keeps enables on; per-byte mode drops them on reads (rw high)
    if (st_r.per_byte && rw_sel) begin
      be_sel = 4'h0;
    end
  end

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // two-stage synchronisers for pin inputs
    st_nxt.hreq_m = bus.hold_req;
    st_nxt.hreq_s = st_r.hreq_m;
    st_nxt.xreq_m = bus.xfer_req;
    st_nxt.xreq_s = st_r.xreq_m;
    st_nxt.xreq_d = st_r.xreq_s;
    st_nxt.rdy_m  = bus.ready;
    st_nxt.rdy_s  = st_r.rdy_m;
    st_nxt.err_m  = bus.error;
    st_nxt.err_s  = st_r.err_m;
    st_nxt.err_d  = st_r.err_s;
    st_nxt.pri_m  = bus.xfer_priority;
    st_nxt.pri_s  = st_r.pri_m;
    st_nxt.ack    = 1'b0;
    st_nxt.done   = 1'b0;
    // free-running bus clock, divide by two
    st_nxt.clk_out = ~st_r.clk_out;
    // bus reset stretch after system reset
    if (st_r.rst_cnt != 4'h0) begin
      st_nxt.rst_cnt = st_r.rst_cnt - 4'h1;
    end
    // record each new error report
    if (st_r.err_s && !st_r.err_d) begin
      st_nxt.errs     = (st_r.errs == 8'hff) ? st_r.errs : st_r.errs + 8'h01;
      st_nxt.err_seen = 1'b1;
    end
    // ownership
    unique case (st_r.own)
      ebh_pkg::EBH_OWN: begin
        // grant only between device transfers
        if (st_r.hreq_s && !st_r.busy && !i_xfer_start) begin
          st_nxt.own = ebh_pkg::EBH_GRANTED;
        end
      end
      ebh_pkg::EBH_GRANTED: begin
        // acknowledge each new master transfer request
        if (st_r.xreq_s && !st_r.xreq_d) begin
          st_nxt.ack = 1'b1;
        end
        if (!st_r.hreq_s) begin
          st_nxt.own = ebh_pkg::EBH_TURN;
        end else if (i_need_bus) begin
          st_nxt.own = ebh_pkg::EBH_RECLAIM;
        end
      end
      ebh_pkg::EBH_RECLAIM: begin
        if (st_r.xreq_s && !st_r.xreq_d) begin
          st_nxt.ack = 1'b1;
        end
        // master is expected to drop hold soon
        if (!st_r.hreq_s) begin
          st_nxt.own = ebh_pkg::EBH_TURN;
        end
      end
      ebh_pkg::EBH_TURN: begin
        // grant already low; one idle cycle before driving
        st_nxt.own = ebh_pkg::EBH_OWN;
      end
    endcase
    // device transfer
    if (!st_r.busy) begin
      if (i_xfer_start && st_r.own == ebh_pkg::EBH_OWN && !st_r.hreq_s) begin
        st_nxt.busy     = 1'b1;
        st_nxt.src      = i_xfer_src;
        st_nxt.wr       = i_xfer_write;
        st_nxt.last     = i_xfer_last;
        st_nxt.addr     = i_xfer_addr;
        st_nxt.wdata    = i_xfer_wdata;
        st_nxt.per_byte = i_be_per_byte;
      end
    end else if (st_r.rdy_s) begin
      st_nxt.busy = 1'b0;
      st_nxt.done = 1'b1;
      if (!st_r.wr) begin
        st_nxt.rdata = bus.data;
      end
    end
    if (!i_rst_n) begin
      st_nxt = '0;
      st_nxt.errs    = ebh_pkg::ERR_CNT_RST;
      st_nxt.rst_cnt = ebh_pkg::RST_STRETCH;
    end
  end

  // ---------------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    st_r <= st_nxt;
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  logic owner; // device owns the shared lines
  assign owner = (st_r.own == ebh_pkg::EBH_OWN);

  assign bus.bus_clk       = st_r.clk_out;
  assign bus.bus_rst       = (st_r.rst_cnt != 4'h0);
  assign bus.hold_grant    = (st_r.own == ebh_pkg::EBH_GRANTED) ||
                             (st_r.own == ebh_pkg::EBH_RECLAIM);
  assign bus.reclaim_req   = (st_r.own == ebh_pkg::EBH_RECLAIM);
  assign bus.xfer_ack      = st_r.ack;
  // shared lines released when master owns; enables are inputs then
  assign bus.dev_ctl_oe_n  = ~owner;
  assign bus.dev_data_oe_n = ~(owner && st_r.busy && st_r.wr);
  assign bus.dev_data_o    = st_r.wdata;
  assign bus.dev_addr_o    = st_r.addr;
  assign bus.dev_be_o      = st_r.busy ? be_sel : 4'h0;
  assign bus.dev_we_o      = st_r.busy ? &be_sel : 1'b0;
  assign bus.dev_rw_o      = st_r.busy ? rw_sel : 1'b1;
  assign bus.dev_last_o    = st_r.busy && st_r.last;

  assign o_xfer_busy    = st_r.busy;
  assign o_xfer_done    = st_r.done;
  assign o_xfer_rdata   = st_r.rdata;
  assign o_master_owns  = ~owner;
  assign o_mst_high_pri = (st_r.pri_s == ebh_pkg::PRI_HIGH);
  assign o_err_count    = st_r.errs;
  assign o_err_seen     = st_r.err_seen;

endmodule // ebh_dev

// File: hdl/ebh_mst.sv
`timescale 1ns/10ps
// external master end: asks for the bus, runs transfers, releases on reclaim
module ebh_mst (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  // user request
  input  wire logic        i_want_bus,
  input  wire logic        i_go,
  input  wire logic        i_low_pri,
  input  wire logic        i_write,
  input  wire logic        i_last,
  input  wire logic [31:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_be,
  input  wire logic        i_error,
  // user status
  output logic             o_owns,
  output logic             o_busy,
  output logic             o_done,
  output logic             o_reclaimed,
  // bus
  ebh_if.mst               bus
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic        hold;      // hold request
    logic        gnt_m;     // grant sync stage 1
    logic        gnt_s;     // grant synced
    logic        rcl_m;     // reclaim sync stage 1
    logic        rcl_s;     // reclaim synced
    logic        ack_m;     // ack sync stage 1
    logic        ack_s;     // ack synced
    logic        req;       // transfer request
    logic        done;      // done pulse
    logic        pri;       // priority level
    logic        wr;        // direction
    logic        last;      // burst last
    logic [31:0] addr;      // address
    logic [31:0] wdata;     // write data
    logic [3:0]  be;        // byte enables
    logic        err;       // error level out
  } ebh_mst_st_t;

  ebh_mst_st_t st_r;   // registered state
  ebh_mst_st_t st_nxt; // next state

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    st_nxt       = st_r;
    st_nxt.gnt_m = bus.hold_grant;
    st_nxt.gnt_s = st_r.gnt_m;
    st_nxt.rcl_m = bus.reclaim_req;
    st_nxt.rcl_s = st_r.rcl_m;
    st_nxt.ack_m = bus.xfer_ack;
    st_nxt.ack_s = st_r.ack_m;
    st_nxt.done  = 1'b0;
    st_nxt.err   = i_error;
    // hold while wanted, dropped at reclaim once idle
    if (st_r.rcl_s && !st_r.req) begin
      st_nxt.hold = 1'b0;
    end else if (!st_r.req) begin
      st_nxt.hold = i_want_bus;
    end
    // transfer request once granted
    if (!st_r.req) begin
      if (i_go && st_r.gnt_s && st_r.hold && !st_r.rcl_s) begin
        st_nxt.req   = 1'b1;
        st_nxt.pri   = i_low_pri;
        st_nxt.wr    = i_write;
        st_nxt.last  = i_last;
        st_nxt.addr  = i_addr;
        st_nxt.wdata = i_wdata;
        st_nxt.be    = i_be;
      end
    end else if (st_r.ack_s) begin
      st_nxt.req  = 1'b0;
      st_nxt.done = 1'b1;
    end
    if (!i_rst_n) begin
      st_nxt = '0;
    end
  end

  // ---------------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    st_r <= st_nxt;
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  logic drive; // master drives shared lines
  assign drive = st_r.gnt_s && st_r.hold;

  assign bus.hold_req      = st_r.hold;
  assign bus.xfer_req      = st_r.req;
  assign bus.xfer_priority = st_r.pri;
  assign bus.error         = st_r.err;
  assign bus.mst_ctl_oe_n  = ~drive;
  assign bus.mst_data_oe_n = ~(drive && st_r.req && st_r.wr);
  assign bus.mst_data_o    = st_r.wdata;
  assign bus.mst_addr_o    = st_r.addr;
  assign bus.mst_be_o      = st_r.be;
  assign bus.mst_we_o      = &st_r.be;
  assign bus.mst_rw_o      = ~st_r.wr;
  assign bus.mst_last_o    = st_r.last;

  assign o_owns      = drive;
  assign o_busy      = st_r.req;
  assign o_done      = st_r.done;
  assign o_reclaimed = st_r.rcl_s;

endmodule // ebh_mst

// File: sim/ebh_monitor.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------------------
// ownership handoff checker
// ---------------------------------------------------------------------------
module ebh_monitor (
  // system clock and reset
  input wire logic       i_sys_clk,
  input wire logic       i_rst_n,
  // device-made clock and reset
  input wire logic       bus_clk,
  input wire logic       bus_rst,
  // ownership handshake
  input wire logic       hold_req,
  input wire logic       hold_grant,
  input wire logic       reclaim_req,
  input wire logic       xfer_req,
  input wire logic       xfer_ack,
  // device drive side
  input wire logic       dev_ctl_oe_n,
  input wire logic       dev_data_oe_n,
  input wire logic [3:0] dev_be_o,
  input wire logic       dev_we_o
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  // bus reset still up for the first cycles after release
  sequence s_rst_held;
    ##1 bus_rst [*6];
  endsequence
  // one idle cycle, then the device drives again
  sequence s_turn;
    dev_ctl_oe_n ##1 !dev_ctl_oe_n;
  endsequence

  AST_GRANT_CAUSE: assert property ($rose(hold_grant) |-> $past(hold_req, 2))
    else $error("grant rose without a held request");
  AST_GRANT_HOLD: assert property (hold_grant && hold_req |=> hold_grant)
    else $error("grant dropped while request still high");
  AST_DRIVE_EXCL: assert property (hold_grant |-> dev_ctl_oe_n && dev_data_oe_n)
    else $error("device drives shared lines while granted");
  AST_TURN_GAP: assert property ($fell(hold_grant) |-> s_turn)
    else $error("no single turn cycle after grant release");
  AST_WE_AND: assert property (!dev_ctl_oe_n |-> dev_we_o == &dev_be_o)
    else $error("write strobe differs from and of enables");
  AST_ACK_LAT: assert property ($rose(xfer_req) && hold_grant |-> ##[2:4] xfer_ack)
    else $error("transfer not acknowledged in time");
  AST_ACK_PULSE: assert property (xfer_ack |-> hold_grant ##1 !xfer_ack)
    else $error("acknowledge not a single pulse while granted");
  AST_RECLAIM_CAUSE: assert property ($rose(reclaim_req) |-> hold_grant)
    else $error("reclaim raised while device already owns");
  AST_CLK_TOGGLE: assert property ($past(i_rst_n) |-> bus_clk != $past(bus_clk))
    else $error("bus clock did not toggle");
  AST_RST_STRETCH: assert property ($rose(i_rst_n) |-> s_rst_held)
    else $error("bus reset released too early");
endmodule // ebh_monitor

// File: sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  // ---------------------------------------------------------------------------
  // clock, reset, counters, stimulus
  // ---------------------------------------------------------------------------
  logic               i_sys_clk   = 1'h0;
  logic               i_rst_n     = 1'h0;
  int                 miscompares = 0;
  int                 cmp_count   = 0;
  ebh_pkg::ebh_src_t  dv_src      = ebh_pkg::EBH_SRC_PERIPH;
  logic               dv_start = 1'h0, dv_write = 1'h0, dv_last = 1'h0, dv_pb = 1'h0;
  logic               dv_prw = 1'h0, dv_drw = 1'h0, dv_need = 1'h0;
  logic [31:0]        dv_addr = 32'h0000_0000, dv_wdata = 32'h0000_0000;
  logic               ms_want = 1'h0, ms_go = 1'h0, ms_lp = 1'h0, ms_err = 1'h0;
  logic [31:0]        ms_addr = 32'h0000_0000, ms_wdata = 32'h0000_0000;
  logic [3:0]         ms_be = 4'h0;
  logic               slv_drv = 1'h0, slv_rdy = 1'h0;
  logic [31:0]        slv_data = 32'h0000_0000, idle_pat = 32'h5a5a_a5a5;
  // design outputs
  logic               dv_busy, dv_done, dv_mowns, dv_hipri, dv_errseen, ms_done, ms_owns, ms_rcl;
  logic [31:0]        dv_rdata;
  logic [7:0]         dv_errs;

  always #4 i_sys_clk = ~i_sys_clk;
  // released lines show a changing pattern, never a stale value
  always @(posedge i_sys_clk) idle_pat <= ~idle_pat;

  ebh_if i_ebh_if ();
  // wire resolution: device, then master, then slave (data lines only), else idle pattern
  assign i_ebh_if.data = !i_ebh_if.dev_data_oe_n ? i_ebh_if.dev_data_o :
                         !i_ebh_if.mst_data_oe_n ? i_ebh_if.mst_data_o : slv_drv ? slv_data : idle_pat;
  assign {i_ebh_if.addr, i_ebh_if.be, i_ebh_if.rw, i_ebh_if.last, i_ebh_if.we} =
    !i_ebh_if.dev_ctl_oe_n ? {i_ebh_if.dev_addr_o, i_ebh_if.dev_be_o, i_ebh_if.dev_rw_o,
                              i_ebh_if.dev_last_o, i_ebh_if.dev_we_o} :
    !i_ebh_if.mst_ctl_oe_n ? {i_ebh_if.mst_addr_o, i_ebh_if.mst_be_o, i_ebh_if.mst_rw_o,
                              i_ebh_if.mst_last_o, i_ebh_if.mst_we_o} : {~idle_pat, idle_pat[6:0]};
  assign i_ebh_if.ready = slv_rdy;

  ebh_dev i_ebh_dev (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_xfer_start(dv_start), .i_xfer_src(dv_src),
    .i_xfer_write(dv_write), .i_xfer_last(dv_last), .i_xfer_addr(dv_addr), .i_xfer_wdata(dv_wdata),
    .i_periph_be(4'h6), .i_dma_be(4'hf), .i_periph_rw(dv_prw), .i_dma_rw(dv_drw), .i_be_per_byte(dv_pb),
    .i_need_bus(dv_need), .o_xfer_busy(dv_busy), .o_xfer_done(dv_done), .o_xfer_rdata(dv_rdata),
    .o_master_owns(dv_mowns), .o_mst_high_pri(dv_hipri), .o_err_count(dv_errs), .o_err_seen(dv_errseen),
    .bus(i_ebh_if.dev));
  ebh_mst i_ebh_mst (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_want_bus(ms_want), .i_go(ms_go),
    .i_low_pri(ms_lp), .i_write(1'h1), .i_last(1'h1), .i_addr(ms_addr), .i_wdata(ms_wdata), .i_be(ms_be),
    .i_error(ms_err), .o_owns(ms_owns), .o_busy(), .o_done(ms_done), .o_reclaimed(ms_rcl), .bus(i_ebh_if.mst));
  ebh_monitor i_ebh_monitor (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .bus_clk(i_ebh_if.bus_clk),
    .bus_rst(i_ebh_if.bus_rst), .hold_req(i_ebh_if.hold_req), .hold_grant(i_ebh_if.hold_grant),
    .reclaim_req(i_ebh_if.reclaim_req), .xfer_req(i_ebh_if.xfer_req), .xfer_ack(i_ebh_if.xfer_ack),
    .dev_ctl_oe_n(i_ebh_if.dev_ctl_oe_n), .dev_data_oe_n(i_ebh_if.dev_data_oe_n),
    .dev_be_o(i_ebh_if.dev_be_o), .dev_we_o(i_ebh_if.dev_we_o));

  // ---------------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------------
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // compare one value and count it
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // signals that a bounded wait can watch
  function automatic logic sig(input int k);
    case (k)
      0: return dv_done;
      1: return i_ebh_if.hold_grant;
      2: return i_ebh_if.xfer_ack;
      3: return ms_done;
      4: return i_ebh_if.reclaim_req;
      default: return i_ebh_if.xfer_req;
    endcase
  endfunction

  // bounded wait; a timeout counts as a mismatch and ends the run
  task automatic wait_sig(input int k, input logic lvl);
    int n;
    n = 0;
    while (sig(k) !== lvl && n < 300) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    if (n >= 300) begin
      miscompares++;
      $display("mismatch wait %0d expected %b seen timeout", k, lvl);
      wrap_up();
    end
  endtask

  // device-owned transfer with a stalling slave
  task automatic dev_xfer(input logic src, input logic wr, input logic pb, input logic [31:0] a, input int stall);
    logic [3:0] eb;
    eb = (pb && !wr) ? 4'h0 : (src ? 4'hf : 4'h6);
    @(posedge i_sys_clk);
    dv_src <= ebh_pkg::ebh_src_t'(src);
    dv_write <= wr;
    dv_last <= wr;
    dv_addr <= a;
    dv_wdata <= ~a;
    dv_pb <= pb;
    dv_prw <= src ? wr : !wr;
    dv_drw <= src ? !wr : wr;
    dv_start <= 1'h1;
    slv_drv <= !wr;
    slv_data <= {a[15:0], a[31:16]};
    @(posedge i_sys_clk);
    dv_start <= 1'h0;
    repeat (stall) @(posedge i_sys_clk);
    #1;
    chk("done before ready", dv_done, 32'h0000_0000);
    chk("addr", i_ebh_if.addr, a);
    chk("rw", i_ebh_if.rw, !wr);
    chk("be", i_ebh_if.be, eb);
    chk("we", i_ebh_if.we, &eb);
    chk("last", i_ebh_if.last, wr);
    if (wr) chk("wdata", i_ebh_if.data, ~a);
    if (pb && !wr) chk("be read per byte", i_ebh_if.be, 4'h0);
    @(posedge i_sys_clk);
    slv_rdy <= 1'h1;
    wait_sig(0, 1'h1);
    if (!wr) chk("rdata", dv_rdata, {a[15:0], a[31:16]});
    @(posedge i_sys_clk);
    slv_rdy <= 1'h0;
    slv_drv <= 1'h0;
  endtask

  // master-owned write, seen from the shared wires
  task automatic mst_xfer(input logic lp, input logic [31:0] a);
    @(posedge i_sys_clk);
    ms_lp <= lp;
    ms_addr <= a;
    ms_wdata <= ~a;
    ms_be <= 4'h9;
    ms_go <= 1'h1;
    // go is a level; keep it up until the master has taken it after its synced grant
    wait_sig(5, 1'h1);
    @(posedge i_sys_clk);
    ms_go <= 1'h0;
    wait_sig(2, 1'h1);
    chk("m addr", i_ebh_if.addr, a);
    chk("m data", i_ebh_if.data, ~a);
    chk("m be", i_ebh_if.be, 4'h9);
    chk("dev released", i_ebh_if.dev_ctl_oe_n, 1'h1);
    chk("m owns", ms_owns, 1'h1);
    wait_sig(3, 1'h1);
    chk("high priority", dv_hipri, !lp);
  endtask

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge i_sys_clk);
    i_rst_n <= 1'h1;
    repeat (2) @(posedge i_sys_clk);
    #1;
    chk("grant", i_ebh_if.hold_grant, 1'h0);
    chk("reclaim", i_ebh_if.reclaim_req, 1'h0);
    chk("dev drives", i_ebh_if.dev_ctl_oe_n, 1'h0);
    chk("bus rst", i_ebh_if.bus_rst, 1'h1);
    chk("errs", dv_errs, 8'h00);
    repeat (10) @(posedge i_sys_clk);
    #1;
    chk("bus rst off", i_ebh_if.bus_rst, 1'h0);
    $display("test reset done");
    // every source, direction and enable mode, growing stalls
    for (int k = 0; k < 8; k++) begin
      dev_xfer(k[0], k[1], k[2], 32'h1000_0000 | 32'(k << 4), 1 + k);
    end
    $display("test device done");
    @(posedge i_sys_clk);
    ms_want <= 1'h1;
    wait_sig(1, 1'h1);
    chk("master owns", dv_mowns, 1'h1);
    chk("data released", i_ebh_if.dev_data_oe_n, 1'h1);
    mst_xfer(1'h0, 32'ha5a5_0010);
    mst_xfer(1'h1, 32'h5a5a_0020);
    // device start while master owns is ignored
    @(posedge i_sys_clk);
    dv_start <= 1'h1;
    @(posedge i_sys_clk);
    dv_start <= 1'h0;
    repeat (3) @(posedge i_sys_clk);
    #1;
    chk("start refused", dv_busy, 1'h0);
    // two error reports
    repeat (2) begin
      @(posedge i_sys_clk);
      ms_err <= 1'h1;
      @(posedge i_sys_clk);
      ms_err <= 1'h0;
      repeat (6) @(posedge i_sys_clk);
    end
    #1;
    chk("err count", dv_errs, 8'h02);
    chk("err seen", dv_errseen, 1'h1);
    $display("test master done");
    @(posedge i_sys_clk);
    dv_need <= 1'h1;
    wait_sig(4, 1'h1);
    chk("grant at reclaim", i_ebh_if.hold_grant, 1'h1);
    @(posedge i_sys_clk);
    ms_want <= 1'h0;
    wait_sig(1, 1'h0);
    chk("turn gap", i_ebh_if.dev_ctl_oe_n, 1'h1);
    chk("master saw reclaim", ms_rcl, 1'h1);
    @(posedge i_sys_clk);
    dv_need <= 1'h0;
    #1;
    chk("dev drives again", i_ebh_if.dev_ctl_oe_n, 1'h0);
    chk("master gone", dv_mowns, 1'h0);
    dev_xfer(1'h1, 1'h1, 1'h1, 32'h2000_0040, 2);
    $display("test reclaim done");
    wrap_up();
  end
endmodule // tb_top
